// file: eld_encoder_loss.v
`timescale 1ns/10ps
`include "eld_defs.vh"
module eld_encoder_loss (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Servo clock tick, one cycle per servo period
  input wire servo_tick,
  // Differential quadrature inputs
  input wire enc_a_p,
  input wire enc_a_n,
  input wire enc_b_p,
  input wire enc_b_n,
  // Sinusoidal converter samples, signed
  input wire [15:0] sin_adc,
  input wire [15:0] cos_adc,
  // Outputs
  output reg motor_stop,
  output wire irq
);
  // Software-visible control and window registers.
  reg [31:0] ctrl;
  reg [`ELD_ST_W-1:0] status;
  reg [`ELD_ST_W-1:0] mask;
  reg [15:0] loss_stop_threshold;
  reg [31:0] nominal;
  reg [31:0] tolerance;

  // Detection state, updated on servo ticks.
  reg [15:0] loss_event_tally;
  reg [15:0] next_loss_event_tally;
  reg quad_pair_fault_flag;
  reg amplitude_sum_fault_flag;

  // Converter samples held for the squaring stage.
  reg [15:0] sin_latch;
  reg [15:0] cos_latch;
  reg latch_strobe;

  // Write address and data wait here until both halves have arrived.
  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  // Results of the sum-of-squares stage.
  wire sum_valid;
  wire sum_bad;
  wire [31:0] sum_of_squares;

  // Mask a word by byte strobes over an old value.
  function [31:0] apply_strb;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      apply_strb = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          apply_strb[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // The stop condition is wanted both for the output and for its sticky event bit.
  function stop_due;
    input [31:0] ctrl_v;
    input [15:0] tally_v;
    input [15:0] limit_v;
    begin
      stop_due = ctrl_v[`ELD_CTRL_STOP_EN] && (tally_v > limit_v);
    end
  endfunction

  // A pair is lost when both lines read the same level.
  // The lines are taken as already synchronous to aclk, so no synchroniser sits here.
  // With single-ended wiring the complement floats, so software must leave detection off then.
  wire pair_lost = (enc_a_p == enc_a_n) || (enc_b_p == enc_b_n);
  wire quad_loss = ctrl[`ELD_CTRL_QUAD_EN] & pair_lost;
  wire sos_loss = ctrl[`ELD_CTRL_SIN_EN] & sum_valid & sum_bad;
  wire stop_now = stop_due(ctrl, loss_event_tally, loss_stop_threshold);

  // Converter samples are latched on the servo tick, then squared.
  // The latch keeps the sample steady while the squaring stage works on it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sin_latch <= 16'h0000;
      cos_latch <= 16'h0000;
      latch_strobe <= 1'b0;
    end else begin
      latch_strobe <= servo_tick;
      if (servo_tick) begin
        sin_latch <= sin_adc;
        cos_latch <= cos_adc;
      end
    end
  end

  // The squaring stage adds a register, so the sine flag trails the tick by three edges.
  eld_sos_check u_sos (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_strobe(latch_strobe),
    .sin_sample(sin_latch),
    .cos_sample(cos_latch),
    .nominal(nominal),
    .tolerance(tolerance),
    .sum_valid(sum_valid),
    .sum_bad(sum_bad),
    .sum_of_squares(sum_of_squares)
  );

  // Next tally: up on a lost pair, down otherwise, clamped at both ends.
  // Holding at all-ones keeps a long outage from wrapping round to a small count.
  always @* begin
    next_loss_event_tally = loss_event_tally;
    if (servo_tick) begin
      if (quad_loss) begin
        if (loss_event_tally != 16'hFFFF) begin
          next_loss_event_tally = loss_event_tally + 16'h0001;
        end
      end else if (loss_event_tally != 16'h0000) begin
        next_loss_event_tally = loss_event_tally - 16'h0001;
      end
    end
  end

  // Tally logic, evaluated once per servo period; the stop output is re-registered on every clock.
  always @(posedge aclk) begin
    if (!aresetn) begin
      loss_event_tally <= 16'h0000;
      quad_pair_fault_flag <= 1'b0;
      amplitude_sum_fault_flag <= 1'b0;
      motor_stop <= 1'b0;
    end else begin
      if (servo_tick) begin
        quad_pair_fault_flag <= quad_loss;
      end
      loss_event_tally <= next_loss_event_tally;
      if (sum_valid) begin
        amplitude_sum_fault_flag <= sos_loss;
      end
      // Stop is a level; it drops when the option is cleared or the tally falls back.
      motor_stop <= stop_now;
    end
  end

  // The write handshake accepts address and data in either order.
  // A held half blocks only its own channel, and a pending response blocks both.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire st_ev_quad = servo_tick && quad_loss;
  wire st_ev_stop = stop_now && !motor_stop;
  wire [`ELD_ST_W-1:0] st_set = {st_ev_stop, sos_loss, st_ev_quad};
  wire [`ELD_ST_W-1:0] st_clr = (do_write && aw_addr == `ELD_OFF_STATUS && w_strb[0]) ?
    w_data[`ELD_ST_W-1:0] : {`ELD_ST_W{1'b0}};
  // Only the low half of the threshold word is kept; the upper lanes read back as zero.
  wire [31:0] limit_word = apply_strb({16'h0000, loss_stop_threshold}, w_data, w_strb);

  // Sticky status; an event in the same cycle as its clear keeps the bit set.
  always @(posedge aclk) begin
    if (!aresetn) begin
      status <= {`ELD_ST_W{1'b0}};
    end else begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  // Register writes and write response.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ELD_RESP_OKAY;
      ctrl <= `ELD_CTRL_RESET;
      mask <= {`ELD_ST_W{1'b0}};
      loss_stop_threshold <= `ELD_LIMIT_RESET;
      nominal <= `ELD_NOMINAL_RESET;
      tolerance <= `ELD_TOL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ELD_RESP_OKAY;
        if (aw_addr == `ELD_OFF_CTRL) begin
          ctrl <= apply_strb(ctrl, w_data, w_strb) & 32'h0000_0007;
        end else if (aw_addr == `ELD_OFF_MASK) begin
          if (w_strb[0]) begin
            mask <= w_data[`ELD_ST_W-1:0];
          end
        end else if (aw_addr == `ELD_OFF_LIMIT) begin
          loss_stop_threshold <= limit_word[15:0];
        end else if (aw_addr == `ELD_OFF_NOMINAL) begin
          nominal <= apply_strb(nominal, w_data, w_strb);
        end else if (aw_addr == `ELD_OFF_TOL) begin
          tolerance <= apply_strb(tolerance, w_data, w_strb);
        end else if (aw_addr == `ELD_OFF_STATUS || aw_addr == `ELD_OFF_TALLY || aw_addr == `ELD_OFF_SAMPLE) begin
          // Status clears through st_clr; tally and sample writes are accepted and dropped.
          s_axi_bresp <= `ELD_RESP_OKAY;
        end else begin
          s_axi_bresp <= `ELD_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data is registered; the answer follows the address by one cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ELD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ELD_RESP_OKAY;
      // Status packs the sticky bits low and the live flags above them.
      if (s_axi_araddr == `ELD_OFF_CTRL) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == `ELD_OFF_STATUS) begin
        s_axi_rdata <= {27'h0000000, amplitude_sum_fault_flag, quad_pair_fault_flag, status};
      end else if (s_axi_araddr == `ELD_OFF_MASK) begin
        s_axi_rdata <= {29'h00000000, mask};
      end else if (s_axi_araddr == `ELD_OFF_TALLY) begin
        s_axi_rdata <= {15'h0000, motor_stop, loss_event_tally};
      end else if (s_axi_araddr == `ELD_OFF_LIMIT) begin
        s_axi_rdata <= {16'h0000, loss_stop_threshold};
      end else if (s_axi_araddr == `ELD_OFF_NOMINAL) begin
        s_axi_rdata <= nominal;
      end else if (s_axi_araddr == `ELD_OFF_TOL) begin
        s_axi_rdata <= tolerance;
      end else if (s_axi_araddr == `ELD_OFF_SAMPLE) begin
        s_axi_rdata <= sum_of_squares;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `ELD_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Level interrupt while any unmasked sticky bit stands.
  // The mask gates only the output; status bits still latch while masked.
  assign irq = |(status & mask);
endmodule // eld_encoder_loss

// file: eld_defs.vh
`ifndef ELD_DEFS_VH
`define ELD_DEFS_VH
// Register byte offsets.
`define ELD_OFF_CTRL 8'h00
`define ELD_OFF_STATUS 8'h04
`define ELD_OFF_MASK 8'h08
`define ELD_OFF_TALLY 8'h0C
`define ELD_OFF_LIMIT 8'h10
`define ELD_OFF_NOMINAL 8'h14
`define ELD_OFF_TOL 8'h18
`define ELD_OFF_SAMPLE 8'h1C
// Control fields.
`define ELD_CTRL_STOP_EN 0
`define ELD_CTRL_QUAD_EN 1
`define ELD_CTRL_SIN_EN 2
`define ELD_CTRL_RESET 32'h0000_0002
// Status fields.
`define ELD_ST_QUAD 0
`define ELD_ST_SOS 1
`define ELD_ST_STOP 2
`define ELD_ST_W 3
// Reset values and field widths.
`define ELD_LIMIT_RESET 16'h0028
`define ELD_NOMINAL_RESET 32'h4000_0000
`define ELD_TOL_RESET 32'h0800_0000
`define ELD_TALLY_W 16
`define ELD_ADC_W 16
// AXI responses.
`define ELD_RESP_OKAY 2'h0
`define ELD_RESP_SLVERR 2'h2
`endif

// file: eld_sos_check.v
`timescale 1ns/10ps
`include "eld_defs.vh"
// Sum of squares of signed sine and cosine samples, checked against a window.
module eld_sos_check (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Samples and strobe
  input wire sample_strobe,
  input wire [15:0] sin_sample,
  input wire [15:0] cos_sample,
  // Window
  input wire [31:0] nominal,
  input wire [31:0] tolerance,
  // Result
  output reg sum_valid,
  output reg sum_bad,
  output reg [31:0] sum_of_squares
);
  wire signed [15:0] s = sin_sample;
  wire signed [15:0] c = cos_sample;
  wire signed [31:0] s2 = s * s;
  wire signed [31:0] c2 = c * c;
  wire [32:0] sum = {1'b0, s2} + {1'b0, c2};
  wire [32:0] lo = {1'b0, nominal} - {1'b0, tolerance};
  wire [32:0] hi = {1'b0, nominal} + {1'b0, tolerance};
  // One register stage; the window is widened by a bit so nominal plus tolerance never wraps.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sum_valid <= 1'b0;
      sum_bad <= 1'b0;
      sum_of_squares <= 32'h0000_0000;
    end else begin
      sum_valid <= sample_strobe;
      if (sample_strobe) begin
        sum_of_squares <= sum[31:0];
        // A tolerance above nominal borrows into bit 32; the lower bound is then zero.
        sum_bad <= (!lo[32] && (sum < lo)) || (sum > hi);
      end
    end
  end
endmodule // eld_sos_check

// file: eld_checker.sv
`timescale 1ns/10ps
// Watches the bus handshakes and the stop output of the loss detector.
module eld_checker (
  // Clock and reset
  input wire aclk, aresetn,
  // Bus handshakes
  input wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire s_axi_rvalid, s_axi_rready,
  input wire [1:0] s_axi_bresp,
  input wire [31:0] s_axi_rdata,
  // Encoder side
  input wire servo_tick, motor_stop
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A write is answered only after both halves are taken.
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_done;
    ##[1:2] s_axi_bvalid;
  endsequence
  AST_BLAT: assert property (s_wr_taken |-> s_wr_done) else $error("write answer late");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_BDONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer repeated");
  AST_AWRDY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_ARRDY: assert property (s_axi_arready == !s_axi_rvalid) else $error("read ready wrong");
  AST_STOP_TICK: assert property ($rose(motor_stop) |-> $past(servo_tick, 2) || $past(servo_tick, 3))
    else $error("stop not after a servo tick");
endmodule // eld_checker

bind eld_encoder_loss eld_checker u_chk (.*);

// file: eld_enc_model.sv
`timescale 1ns/10ps
// Encoder at the far side; it can be detached or lose its analog amplitude.
module eld_enc_model (
  // Clock and faults
  input wire aclk,
  input wire lost,
  input wire sine_off,
  // Encoder lines
  output reg enc_a_p, enc_a_n, enc_b_p, enc_b_n,
  output reg [15:0] sin_adc, cos_adc
);
  reg [1:0] ph;
  initial begin
    ph = 2'h0;
    {enc_a_p, enc_a_n, enc_b_p, enc_b_n} = 4'hA;
    {sin_adc, cos_adc} = 32'h0;
  end
  // Lines step every cycle so a wrong sample point would still be caught.
  always @(posedge aclk) begin
    ph <= ph + 2'h1;
    if (lost) begin
      {enc_a_p, enc_a_n, enc_b_p, enc_b_n} <= 4'hF;
    end else begin
      {enc_a_p, enc_a_n} <= {ph[1], !ph[1]};
      {enc_b_p, enc_b_n} <= {ph[1] ^ ph[0], !(ph[1] ^ ph[0])};
    end
    // Full-scale phasor; the square of 16'h8001 equals that of 16'h7FFF.
    case ({sine_off, ph})
      3'h0: {sin_adc, cos_adc} <= 32'h7FFF_0000;
      3'h1: {sin_adc, cos_adc} <= 32'h0000_7FFF;
      3'h2: {sin_adc, cos_adc} <= 32'h8001_0000;
      3'h3: {sin_adc, cos_adc} <= 32'h0000_8001;
      default: {sin_adc, cos_adc} <= 32'h0;
    endcase
  end
endmodule // eld_enc_model

// file: tb_top.sv
`timescale 1ns/10ps
`include "eld_defs.vh"
module tb_top;
  reg aclk, aresetn, servo_tick, lost, sine_off;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire enc_a_p, enc_a_n, enc_b_p, enc_b_n, motor_stop, irq;
  wire [15:0] sin_adc, cos_adc;
  reg [31:0] rv;
  reg [1:0] resp;
  integer error_cnt, n_compared, cyc;
  eld_encoder_loss u_dut (.*);
  eld_enc_model u_enc (.*);
  // Free-running clock at 125 MHz.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Hang guard; the tests need well under a thousand cycles.
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [2:0] f;
    begin
      f = 3'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (f != 3'h7) begin
        @(posedge aclk);
        if (!f[0] && s_axi_awready) begin
          s_axi_awvalid <= 1'b0;
          f[0] = 1'b1;
        end
        if (!f[1] && s_axi_wready) begin
          s_axi_wvalid <= 1'b0;
          f[1] = 1'b1;
        end
        if (!f[2] && s_axi_bvalid) begin
          s_axi_bready <= 1'b0;
          resp = s_axi_bresp;
          f[2] = 1'b1;
        end
      end
      // One idle edge keeps bready from being lowered and raised in one step.
      @(posedge aclk);
    end
  endtask
  task rd(input [7:0] a);
    reg [1:0] f;
    begin
      f = 2'h0;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      while (f != 2'h3) begin
        @(posedge aclk);
        if (!f[0] && s_axi_arready) begin
          s_axi_arvalid <= 1'b0;
          f[0] = 1'b1;
        end
        if (!f[1] && s_axi_rvalid) begin
          s_axi_rready <= 1'b0;
          {resp, rv} = {s_axi_rresp, s_axi_rdata};
          f[1] = 1'b1;
        end
      end
      // One idle edge keeps rready from being lowered and raised in one step.
      @(posedge aclk);
    end
  endtask
  // Spacing of five cycles leaves the sine path room to settle.
  task tick(input integer n);
    repeat (n) begin
      servo_tick <= 1'b1;
      @(posedge aclk);
      servo_tick <= 1'b0;
      repeat (5) @(posedge aclk);
    end
  endtask
  task t_regs;
    begin
      rd(`ELD_OFF_CTRL); chk(rv, `ELD_CTRL_RESET);
      rd(`ELD_OFF_LIMIT); chk(rv, 32'h28);
      rd(`ELD_OFF_TOL); chk(rv, `ELD_TOL_RESET);
      rd(`ELD_OFF_NOMINAL); chk(rv, `ELD_NOMINAL_RESET);
      rd(8'h20); chk(resp, `ELD_RESP_SLVERR);
      chk(rv, 32'h0);
      wr(8'h20, 32'h1); chk(resp, `ELD_RESP_SLVERR);
      $display("regs done");
    end
  endtask
  // The encoder model shows a fault one edge after it is asked for, so each scenario waits that edge.
  task t_quad;
    begin
      wr(`ELD_OFF_MASK, 32'h3);
      tick(2); rd(`ELD_OFF_TALLY); chk(rv, 32'h0);
      lost <= 1'b1;
      @(posedge aclk);
      tick(3); rd(`ELD_OFF_TALLY); chk(rv, 32'h3);
      rd(`ELD_OFF_STATUS); chk(rv[4:0], 5'h09);
      chk(irq, 1'b1);
      lost <= 1'b0;
      @(posedge aclk);
      tick(1); rd(`ELD_OFF_TALLY); chk(rv, 32'h2);
      wr(`ELD_OFF_STATUS, 32'h1); chk(irq, 1'b0);
      $display("quad done");
    end
  endtask
  task t_stop;
    begin
      wr(`ELD_OFF_LIMIT, 32'h28);
      wr(`ELD_OFF_CTRL, 32'h3);
      lost <= 1'b1;
      @(posedge aclk);
      tick(38); chk(motor_stop, 1'b0);
      tick(1); chk(motor_stop, 1'b1);
      rd(`ELD_OFF_TALLY); chk(rv, 32'h1_0029);
      rd(`ELD_OFF_STATUS); chk(rv[2], 1'b1);
      // Stop option off but detection on: the stop drops while the tally keeps rising.
      wr(`ELD_OFF_CTRL, 32'h2); chk(motor_stop, 1'b0);
      tick(1); rd(`ELD_OFF_TALLY); chk(rv, 32'h2A);
      lost <= 1'b0;
      $display("stop done");
    end
  endtask
  task t_sine;
    begin
      wr(`ELD_OFF_STATUS, 32'h7);
      wr(`ELD_OFF_CTRL, 32'h4);
      tick(2); rd(`ELD_OFF_STATUS); chk(rv[1], 1'b0);
      rd(`ELD_OFF_SAMPLE); chk(rv, 32'h3FFF_0001);
      sine_off <= 1'b1;
      @(posedge aclk);
      tick(1); rd(`ELD_OFF_STATUS); chk(rv[4:0], 5'h12);
      chk(irq, 1'b1);
      rd(`ELD_OFF_SAMPLE); chk(rv, 32'h0);
      $display("sine done");
    end
  endtask
  // A second reset in mid-run must bring back the reset state.
  task t_reset;
    begin
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(irq, 1'b0);
      chk(motor_stop, 1'b0);
      rd(`ELD_OFF_TALLY);
      chk(rv, 32'h0);
      rd(`ELD_OFF_CTRL);
      chk(rv, `ELD_CTRL_RESET);
      $display("reset done");
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // Reset for four cycles, then run the scenarios in turn.
  initial begin
    {error_cnt, n_compared, cyc} = 0;
    {aresetn, servo_tick, lost, sine_off} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_quad;
    t_stop;
    t_sine;
    t_reset;
    finish_test;
  end
endmodule // tb_top
